// *** src/acmc_regs.svh ***
`ifndef ACMC_REGS_SVH
`define ACMC_REGS_SVH

// ----------------------------------------------------------------------
// Register placement
// ----------------------------------------------------------------------
`define ACMC_CTRL_ADDR 8'hd8
`define ACMC_CTRL_RESET 8'h00
`define ACMC_BIT_PAGE 5'h1b
`define ACMC_UNMAPPED_READ 8'h00

// ----------------------------------------------------------------------
// Field positions in adc_mode_channel_control
// ----------------------------------------------------------------------
`define ACMC_DONE_BIT 7
`define ACMC_SERIAL_BIT 6
`define ACMC_CONT_BIT 5
`define ACMC_SINGLE_BIT 4
`define ACMC_CHAN_MSB 3
`define ACMC_CHAN_LSB 0

// ----------------------------------------------------------------------
// ADC clock divide ratios by select code
// ----------------------------------------------------------------------
`define ACMC_DIV_CODE_8 2'h0
`define ACMC_DIV_CODE_4 2'h1
`define ACMC_DIV_CODE_16 2'h2
`define ACMC_DIV_CODE_32 2'h3
`define ACMC_DIV_8 6'h08
`define ACMC_DIV_4 6'h04
`define ACMC_DIV_16 6'h10
`define ACMC_DIV_32 6'h20

// ----------------------------------------------------------------------
// Acquisition length: code plus one ADC clocks (code 11 gives four)
// ----------------------------------------------------------------------
`define ACMC_ACQ_OFFSET 6'h01

// ----------------------------------------------------------------------
// Serial transfer phases
// ----------------------------------------------------------------------
`define ACMC_SER_IDLE 2'h0
`define ACMC_SER_HIGH 2'h1
`define ACMC_SER_LOW 2'h2

`endif

// *** src/acmc_pkg.sv ***
package acmc_pkg;

	typedef logic [3:0] acmc_chan_t;
	typedef logic [11:0] acmc_result_t;
	typedef logic [7:0] acmc_byte_t;

	typedef enum logic [1:0] {
		ACMC_IDLE = 2'b00,
		ACMC_ACQ = 2'b01,
		ACMC_CONV = 2'b10,
		ACMC_DONE = 2'b11
	} acmc_state_e;

endpackage : acmc_pkg

// *** src/acmc_div.sv ***
`timescale 1ns/1ps
`include "acmc_regs.svh"

module acmc_div (
	input logic clk,
	input logic rst_n,
	input logic [1:0] div_sel,
	output logic adc_clk,
	output logic adc_tick
);
	import acmc_pkg::*;

	logic [5:0] cnt;
	logic [5:0] ratio;
	logic [5:0] half;

	// ------------------------------------------------------------------
	// Ratio decode
	// ------------------------------------------------------------------
	function automatic logic [5:0] div_ratio(input logic [1:0] sel);
		logic [5:0] r;
		r = `ACMC_DIV_8;
		unique case (sel)
			`ACMC_DIV_CODE_8: r = `ACMC_DIV_8;
			`ACMC_DIV_CODE_4: r = `ACMC_DIV_4;
			`ACMC_DIV_CODE_16: r = `ACMC_DIV_16;
			`ACMC_DIV_CODE_32: r = `ACMC_DIV_32;
		endcase
		return r;
	endfunction : div_ratio

	assign ratio = div_ratio(div_sel);
	assign half = {1'b0, ratio[5:1]};

	// ------------------------------------------------------------------
	// Divider counter
	// ------------------------------------------------------------------
	// Wrap on >= so a smaller ratio chosen mid-count cannot overrun
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 6'h00;
		end else if (cnt >= ratio - 6'h01) begin
			cnt <= 6'h00;
		end else begin
			cnt <= cnt + 6'h01;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			adc_clk <= 1'b0;
			adc_tick <= 1'b0;
		end else begin
			adc_clk <= (cnt < half);
			adc_tick <= (cnt >= ratio - 6'h01);
		end
	end

endmodule : acmc_div

// *** src/acmc_ctrl.sv ***
// Behaviour
// - Control register sits at address D8H and resets to 00H.
// - Each register bit can be written singly through the bit port.
// - Bit7 done, bit6 serial, bit5 continuous, bit4 single, bits3-0 channel.
// - Done flag sets when a conversion cycle finishes.
// - Done flag clears on interrupt vectoring if enabled, else software clears it.
// - With serial enable set, each result is written to the serial buffer.
// - With continuous set, a new conversion starts when one completes.
// - Continuous runs use divider and acquisition settings from timing config.
// - Writing one to single start starts exactly one conversion.
// - Single start bit clears itself when its conversion completes.
// - Conversion uses the channel number in the channel field.
// - ADC clock divide: 00 eight, 01 four, 10 sixteen, 11 thirty-two.
// - Acquisition lasts the selected ADC clocks; code 11 gives four.
`timescale 1ns/1ps
`include "acmc_regs.svh"

module acmc_ctrl #(
	parameter int CONV_CLKS = 14
) (
	input logic CLK,
	input logic RST_N,
	input logic [7:0] SFR_ADDR,
	input logic SFR_WR,
	input logic SFR_RD,
	input acmc_pkg::acmc_byte_t SFR_WDATA,
	output acmc_pkg::acmc_byte_t SFR_RDATA,
	input logic [7:0] BIT_ADDR,
	input logic BIT_WR,
	input logic BIT_WDATA,
	input logic BIT_RD,
	output logic BIT_RDATA,
	input logic [1:0] TIMING_DIV_SEL,
	input logic [1:0] TIMING_ACQ_SEL,
	input logic INT_ENABLE,
	input logic INT_VECTOR,
	output logic ADC_CLK,
	output logic ADC_TRACK,
	output logic ADC_CONVERT,
	output acmc_pkg::acmc_chan_t ADC_CHANNEL,
	input acmc_pkg::acmc_result_t ADC_RESULT_IN,
	output acmc_pkg::acmc_result_t RESULT,
	output logic RESULT_VALID,
	output logic SERIAL_TX_WR,
	output acmc_pkg::acmc_byte_t SERIAL_TX_DATA,
	output logic CONV_DONE_FLAG
);
	import acmc_pkg::*;

	localparam logic [5:0] CONV_LEN = 6'(CONV_CLKS);

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	acmc_byte_t ctrl;
	acmc_byte_t wr_mask;
	acmc_byte_t wr_val;
	acmc_state_e state;
	acmc_state_e next_state;
	logic [5:0] tick_cnt;
	logic [5:0] acq_len;
	logic run_single;
	logic adc_tick;
	logic start_evt;
	logic done_evt;
	logic restart;
	logic [1:0] ser_phase;
	acmc_result_t ser_hold;
	acmc_chan_t ser_chan;

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	function automatic logic byte_hit(input logic [7:0] addr);
		return addr == `ACMC_CTRL_ADDR;
	endfunction : byte_hit

	function automatic logic bit_hit(input logic [7:0] addr);
		return addr[7:3] == `ACMC_BIT_PAGE;
	endfunction : bit_hit

	function automatic logic [5:0] acq_clocks(input logic [1:0] sel);
		return {4'h0, sel} + `ACMC_ACQ_OFFSET;
	endfunction : acq_clocks

	// ------------------------------------------------------------------
	// ADC clock divider
	// ------------------------------------------------------------------
	acmc_div u_div (
		.clk(CLK),
		.rst_n(RST_N),
		.div_sel(TIMING_DIV_SEL),
		.adc_clk(ADC_CLK),
		.adc_tick(adc_tick)
	);

	// ------------------------------------------------------------------
	// Write decode
	// ------------------------------------------------------------------
	// A byte write beats a bit write in the same cycle
	always_comb begin
		wr_mask = 8'h00;
		wr_val = ctrl;
		if (SFR_WR && byte_hit(SFR_ADDR)) begin
			wr_mask = 8'hff;
			wr_val = SFR_WDATA;
		end else if (BIT_WR && bit_hit(BIT_ADDR)) begin
			wr_mask[BIT_ADDR[2:0]] = 1'b1;
			wr_val[BIT_ADDR[2:0]] = BIT_WDATA;
		end
	end

	// ------------------------------------------------------------------
	// Control register fields
	// ------------------------------------------------------------------
	// Hardware set of the done flag wins over any clear
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			ctrl[`ACMC_DONE_BIT] <= 1'b0;
		end else if (done_evt) begin
			ctrl[`ACMC_DONE_BIT] <= 1'b1;
		end else if (wr_mask[`ACMC_DONE_BIT]) begin
			ctrl[`ACMC_DONE_BIT] <= wr_val[`ACMC_DONE_BIT];
		end else if (INT_ENABLE && INT_VECTOR) begin
			ctrl[`ACMC_DONE_BIT] <= 1'b0;
		end
	end

	// Software write of one wins over the self-clear
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			ctrl[`ACMC_SINGLE_BIT] <= 1'b0;
		end else if (wr_mask[`ACMC_SINGLE_BIT]) begin
			ctrl[`ACMC_SINGLE_BIT] <= wr_val[`ACMC_SINGLE_BIT];
		end else if (done_evt && run_single) begin
			ctrl[`ACMC_SINGLE_BIT] <= 1'b0;
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			ctrl[`ACMC_SERIAL_BIT] <= 1'b0;
			ctrl[`ACMC_CONT_BIT] <= 1'b0;
			ctrl[`ACMC_CHAN_MSB:`ACMC_CHAN_LSB] <= 4'h0;
		end else begin
			if (wr_mask[`ACMC_SERIAL_BIT]) begin
				ctrl[`ACMC_SERIAL_BIT] <= wr_val[`ACMC_SERIAL_BIT];
			end
			if (wr_mask[`ACMC_CONT_BIT]) begin
				ctrl[`ACMC_CONT_BIT] <= wr_val[`ACMC_CONT_BIT];
			end
			ctrl[`ACMC_CHAN_MSB:`ACMC_CHAN_LSB] <= wr_val[`ACMC_CHAN_MSB:`ACMC_CHAN_LSB];
		end
	end

	assign CONV_DONE_FLAG = ctrl[`ACMC_DONE_BIT];

	// ------------------------------------------------------------------
	// Read port
	// ------------------------------------------------------------------
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			SFR_RDATA <= `ACMC_UNMAPPED_READ;
		end else if (SFR_RD) begin
			SFR_RDATA <= byte_hit(SFR_ADDR) ? ctrl : `ACMC_UNMAPPED_READ;
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			BIT_RDATA <= 1'b0;
		end else if (BIT_RD) begin
			BIT_RDATA <= bit_hit(BIT_ADDR) ? ctrl[BIT_ADDR[2:0]] : 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// Conversion sequencer
	// ------------------------------------------------------------------
	assign acq_len = acq_clocks(TIMING_ACQ_SEL);
	// Continuous bit sampled only at a boundary, so clearing it never aborts
	assign restart = ctrl[`ACMC_CONT_BIT] || (ctrl[`ACMC_SINGLE_BIT] && !run_single);
	assign start_evt = (state == ACMC_IDLE) && (ctrl[`ACMC_SINGLE_BIT] || ctrl[`ACMC_CONT_BIT]);
	assign done_evt = (state == ACMC_DONE);

	always_comb begin
		next_state = state;
		unique case (state)
			ACMC_IDLE: begin
				if (start_evt) begin
					next_state = ACMC_ACQ;
				end
			end
			ACMC_ACQ: begin
				if (adc_tick && tick_cnt >= acq_len - 6'h01) begin
					next_state = ACMC_CONV;
				end
			end
			ACMC_CONV: begin
				if (adc_tick && tick_cnt >= CONV_LEN - 6'h01) begin
					next_state = ACMC_DONE;
				end
			end
			ACMC_DONE: begin
				next_state = restart ? ACMC_ACQ : ACMC_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			state <= ACMC_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// ADC clock count within the current phase
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			tick_cnt <= 6'h00;
		end else if (next_state != state) begin
			tick_cnt <= 6'h00;
		end else if (adc_tick) begin
			tick_cnt <= tick_cnt + 6'h01;
		end
	end

	// Origin of the run: single or continuous
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			run_single <= 1'b0;
		end else if (start_evt) begin
			run_single <= ctrl[`ACMC_SINGLE_BIT];
		end else if (done_evt && restart) begin
			run_single <= !ctrl[`ACMC_CONT_BIT];
		end
	end

	// Channel latched as each conversion starts
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			ADC_CHANNEL <= 4'h0;
		end else if (start_evt || (done_evt && restart)) begin
			ADC_CHANNEL <= ctrl[`ACMC_CHAN_MSB:`ACMC_CHAN_LSB];
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			ADC_TRACK <= 1'b0;
			ADC_CONVERT <= 1'b0;
		end else begin
			ADC_TRACK <= (next_state == ACMC_ACQ);
			ADC_CONVERT <= (next_state == ACMC_CONV);
		end
	end

	// ------------------------------------------------------------------
	// Result capture
	// ------------------------------------------------------------------
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			RESULT <= 12'h000;
			RESULT_VALID <= 1'b0;
		end else begin
			RESULT_VALID <= done_evt;
			if (done_evt) begin
				RESULT <= ADC_RESULT_IN;
			end
		end
	end

	// ------------------------------------------------------------------
	// Direct transfer to serial buffer
	// ------------------------------------------------------------------
	// Two writes: channel with high nibble, then low byte
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			ser_phase <= `ACMC_SER_IDLE;
			ser_hold <= 12'h000;
			ser_chan <= 4'h0;
		end else if (done_evt && ctrl[`ACMC_SERIAL_BIT]) begin
			ser_phase <= `ACMC_SER_HIGH;
			ser_hold <= ADC_RESULT_IN;
			ser_chan <= ADC_CHANNEL;
		end else if (ser_phase == `ACMC_SER_HIGH) begin
			ser_phase <= `ACMC_SER_LOW;
		end else begin
			ser_phase <= `ACMC_SER_IDLE;
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			SERIAL_TX_WR <= 1'b0;
			SERIAL_TX_DATA <= 8'h00;
		end else begin
			SERIAL_TX_WR <= 1'b0;
			if (ser_phase == `ACMC_SER_HIGH) begin
				SERIAL_TX_WR <= 1'b1;
				SERIAL_TX_DATA <= {ser_chan, ser_hold[11:8]};
			end else if (ser_phase == `ACMC_SER_LOW) begin
				SERIAL_TX_WR <= 1'b1;
				SERIAL_TX_DATA <= ser_hold[7:0];
			end
		end
	end

endmodule : acmc_ctrl

// *** test/acmc_ctrl_assertions.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Port checker for the conversion control block
// ----------------------------------------------------------------------
module acmc_ctrl_assertions (
	input logic CLK,
	input logic RST_N,
	input logic [7:0] SFR_ADDR,
	input logic SFR_RD,
	input acmc_pkg::acmc_byte_t SFR_RDATA,
	input logic ADC_TRACK,
	input logic ADC_CONVERT,
	input acmc_pkg::acmc_chan_t ADC_CHANNEL,
	input acmc_pkg::acmc_result_t RESULT,
	input logic RESULT_VALID,
	input logic SERIAL_TX_WR,
	input acmc_pkg::acmc_byte_t SERIAL_TX_DATA,
	input logic CONV_DONE_FLAG
);
	import acmc_pkg::*;
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);

	sequence hi_byte;
		SERIAL_TX_WR && SERIAL_TX_DATA[3:0] == RESULT[11:8];
	endsequence
	sequence lo_byte;
		SERIAL_TX_WR && SERIAL_TX_DATA == RESULT[7:0];
	endsequence

	unmapped_read_a: assert property (SFR_RD && SFR_ADDR != 8'hd8 |=> SFR_RDATA == 8'h00)
		else $error("unmapped read not zero");
	flag_readback_a: assert property (SFR_RD && SFR_ADDR == 8'hd8 |=> SFR_RDATA[7] == $past(CONV_DONE_FLAG))
		else $error("bit 7 differs from done flag");
	valid_flag_a: assert property (RESULT_VALID |-> CONV_DONE_FLAG)
		else $error("result without done flag");
	valid_pulse_a: assert property (RESULT_VALID |=> !RESULT_VALID)
		else $error("result valid longer than one cycle");
	serial_pair_a: assert property ($rose(SERIAL_TX_WR) |-> hi_byte ##1 lo_byte ##1 !SERIAL_TX_WR)
		else $error("serial byte pair wrong");
	serial_cause_a: assert property ($rose(SERIAL_TX_WR) |-> $past(RESULT_VALID))
		else $error("serial write without result");
	phase_excl_a: assert property (!(ADC_TRACK && ADC_CONVERT))
		else $error("track and convert together");
	phase_order_a: assert property ($fell(ADC_TRACK) |-> ADC_CONVERT)
		else $error("conversion does not follow acquisition");
	chan_stable_a: assert property (ADC_CONVERT |-> $stable(ADC_CHANNEL))
		else $error("channel moved during conversion");
endmodule : acmc_ctrl_assertions

bind acmc_ctrl acmc_ctrl_assertions u_chk (.CLK(CLK), .RST_N(RST_N), .SFR_ADDR(SFR_ADDR), .SFR_RD(SFR_RD),
	.SFR_RDATA(SFR_RDATA), .ADC_TRACK(ADC_TRACK), .ADC_CONVERT(ADC_CONVERT), .ADC_CHANNEL(ADC_CHANNEL),
	.RESULT(RESULT), .RESULT_VALID(RESULT_VALID), .SERIAL_TX_WR(SERIAL_TX_WR),
	.SERIAL_TX_DATA(SERIAL_TX_DATA), .CONV_DONE_FLAG(CONV_DONE_FLAG));

// *** test/tb.sv ***
`timescale 1ns/1ps
module tb;
	import acmc_pkg::*;
	logic CLK = 0, RST_N = 0, SFR_WR = 0, SFR_RD = 0, BIT_WR = 0, BIT_WDATA = 0, BIT_RD = 0;
	logic INT_ENABLE = 0, INT_VECTOR = 0, ADC_CLK, ADC_TRACK, ADC_CONVERT, RESULT_VALID, SERIAL_TX_WR;
	logic CONV_DONE_FLAG, BIT_RDATA, bv;
	logic [7:0] SFR_ADDR = 0, BIT_ADDR = 0;
	logic [1:0] TIMING_DIV_SEL = 2'h1, TIMING_ACQ_SEL = 2'h3;
	acmc_byte_t SFR_WDATA = 0, SFR_RDATA, SERIAL_TX_DATA, d;
	acmc_chan_t ADC_CHANNEL;
	acmc_result_t ADC_RESULT_IN = 12'ha5c, RESULT;
	int n_errors = 0, checks = 0, cyc = 0, n_valid = 0, trk = 0, n;
	acmc_byte_t ser_q[$];

	acmc_ctrl #(.CONV_CLKS(2)) dut (.CLK(CLK), .RST_N(RST_N), .SFR_ADDR(SFR_ADDR), .SFR_WR(SFR_WR),
		.SFR_RD(SFR_RD), .SFR_WDATA(SFR_WDATA), .SFR_RDATA(SFR_RDATA), .BIT_ADDR(BIT_ADDR), .BIT_WR(BIT_WR),
		.BIT_WDATA(BIT_WDATA), .BIT_RD(BIT_RD), .BIT_RDATA(BIT_RDATA), .TIMING_DIV_SEL(TIMING_DIV_SEL),
		.TIMING_ACQ_SEL(TIMING_ACQ_SEL), .INT_ENABLE(INT_ENABLE), .INT_VECTOR(INT_VECTOR), .ADC_CLK(ADC_CLK),
		.ADC_TRACK(ADC_TRACK), .ADC_CONVERT(ADC_CONVERT), .ADC_CHANNEL(ADC_CHANNEL),
		.ADC_RESULT_IN(ADC_RESULT_IN), .RESULT(RESULT), .RESULT_VALID(RESULT_VALID),
		.SERIAL_TX_WR(SERIAL_TX_WR), .SERIAL_TX_DATA(SERIAL_TX_DATA), .CONV_DONE_FLAG(CONV_DONE_FLAG));

	always #10 CLK = ~CLK;
	always @(posedge CLK) begin
		cyc++;
		if (RESULT_VALID === 1'b1) n_valid++;
		if (SERIAL_TX_WR === 1'b1) ser_q.push_back(SERIAL_TX_DATA);
		if (cyc == 20000) begin
			n_errors++;
			conclude();
		end
	end

	task conclude();
		if (n_errors == 0 && checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : conclude

	task check(input string what, input logic [11:0] seen, input logic [11:0] exp);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task wr(input logic [7:0] a, input acmc_byte_t v);
		@(posedge CLK);
		SFR_ADDR <= a;
		SFR_WDATA <= v;
		SFR_WR <= 1'b1;
		@(posedge CLK);
		SFR_WR <= 1'b0;
	endtask : wr

	task rd(input logic [7:0] a, output acmc_byte_t v);
		@(posedge CLK);
		SFR_ADDR <= a;
		SFR_RD <= 1'b1;
		@(posedge CLK);
		SFR_RD <= 1'b0;
		@(negedge CLK);
		v = SFR_RDATA;
	endtask : rd

	task bwr(input int b, input logic v);
		@(posedge CLK);
		BIT_ADDR <= 8'hd8 + 8'(b);
		BIT_WDATA <= v;
		BIT_WR <= 1'b1;
		@(posedge CLK);
		BIT_WR <= 1'b0;
	endtask : bwr

	task brd(input int b, output logic v);
		@(posedge CLK);
		BIT_ADDR <= 8'hd8 + 8'(b);
		BIT_RD <= 1'b1;
		@(posedge CLK);
		BIT_RD <= 1'b0;
		@(negedge CLK);
		v = BIT_RDATA;
	endtask : brd

	// Waits for the next result, counting acquisition cycles on the way
	task wait_valid();
		trk = (ADC_TRACK === 1'b1) ? 1 : 0;
		for (int i = 0; i < 400; i++) begin
			@(negedge CLK);
			if (ADC_TRACK === 1'b1) trk++;
			if (RESULT_VALID === 1'b1) break;
		end
		check("result_valid", RESULT_VALID, 12'h1);
	endtask : wait_valid

	task rise(output int c);
		logic p;
		c = 0;
		do begin
			p = ADC_CLK;
			@(negedge CLK);
			c++;
		end while (!(p === 1'b0 && ADC_CLK === 1'b1) && c < 100);
	endtask : rise

	// ----------------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------------
	task t_reset();
		rd(8'hd8, d);
		check("ctrl_reset", d, 12'h00);
		rd(8'hd9, d);
		check("unmapped", d, 12'h00);
	endtask : t_reset

	task t_bits();
		bwr(2, 1'b1);
		bwr(0, 1'b1);
		rd(8'hd8, d);
		check("bit_set", d, 12'h05);
		bwr(2, 1'b0);
		bwr(7, 1'b1);
		rd(8'hd8, d);
		check("bit_mix", d, 12'h81);
		check("flag_port", CONV_DONE_FLAG, 12'h1);
		brd(7, bv);
		check("bit_read", bv, 12'h1);
		bwr(7, 1'b0);
		brd(7, bv);
		check("sw_clear", bv, 12'h0);
		check("flag_cleared", CONV_DONE_FLAG, 12'h0);
		wr(8'hd8, 8'h00);
	endtask : t_bits

	task t_div();
		logic [11:0] ratio[4];
		ratio = '{12'd8, 12'd4, 12'd16, 12'd32};
		for (int i = 0; i < 4; i++) begin
			@(posedge CLK);
			TIMING_DIV_SEL <= 2'(i);
			rise(n);
			rise(n);
			check("adc_clk_period", 12'(n), ratio[i]);
		end
		@(posedge CLK);
		TIMING_DIV_SEL <= 2'h1;
	endtask : t_div

	task t_single();
		wr(8'hd8, 8'h13);
		wait_valid();
		check("channel", ADC_CHANNEL, 12'h3);
		check("result", RESULT, 12'ha5c);
		check("acq_len", 12'(trk >= 13 && trk <= 17), 12'h1);
		rd(8'hd8, d);
		check("after_single", d, 12'h83);
		n = n_valid;
		repeat (200) @(posedge CLK);
		check("one_conv", 12'(n_valid - n), 12'h0);
		INT_VECTOR <= 1'b1;
		@(posedge CLK) INT_VECTOR <= 1'b0;
		rd(8'hd8, d);
		check("vector_masked", d, 12'h83);
		@(posedge CLK);
		INT_ENABLE <= 1'b1;
		INT_VECTOR <= 1'b1;
		@(posedge CLK) INT_VECTOR <= 1'b0;
		rd(8'hd8, d);
		check("vector_clear", d, 12'h03);
	endtask : t_single

	task t_cont();
		ser_q.delete();
		@(posedge CLK);
		TIMING_DIV_SEL <= 2'h2;
		wr(8'hd8, 8'h62);
		wait_valid();
		wait_valid();
		check("cont_acq_len", 12'(trk >= 49 && trk <= 64), 12'h1);
		repeat (4) @(posedge CLK);
		check("ser_count", 12'(ser_q.size()), 12'h4);
		check("ser_hi", ser_q[0], 12'h2a);
		check("ser_lo", ser_q[1], 12'h5c);
		for (int i = 0; i < 400 && ADC_CONVERT !== 1'b1; i++) @(negedge CLK);
		n = n_valid;
		wr(8'hd8, 8'h42);
		repeat (300) @(posedge CLK);
		check("cont_stop", 12'(n_valid - n), 12'h1);
		check("flag_after_stop", CONV_DONE_FLAG, 12'h1);
	endtask : t_cont

	initial begin
		repeat (3) @(posedge CLK);
		RST_N <= 1'b1;
		t_reset();
		t_bits();
		t_div();
		t_single();
		t_cont();
		conclude();
	end
endmodule : tb
